/* core/fw_pkg.sv */
package fw_pkg;

	localparam int CLK_PERIOD_NS  = 10;
	localparam int SAMPLE_TIME_NS = 50000;
	localparam int SAMPLE_CYCLES  = SAMPLE_TIME_NS / CLK_PERIOD_NS;

	localparam int           WHEEL_BIT   = 7;
	localparam int           SPEED_LSB   = 4;
	localparam logic [3:0]   FILTER_LAST = 4'h9;
	localparam logic [3:0]   HOME_POS    = 4'h0;
	localparam logic [7:0]   CMD_BATCH   = 8'hDF;
	localparam logic [7:0]   CMD_ONLINE  = 8'hEE;
	localparam logic [7:0]   CMD_OPEN_A  = 8'hAA;
	localparam logic [7:0]   CMD_COND_A  = 8'hAB;
	localparam logic [7:0]   CMD_CLOSE_A = 8'hAC;
	localparam logic [7:0]   CMD_OPEN_B  = 8'hBA;
	localparam logic [7:0]   CMD_COND_B  = 8'hBB;
	localparam logic [7:0]   CMD_CLOSE_B = 8'hBC;
	localparam logic [1:0]   BATCH_LAST  = 2'h3;

	localparam logic [1:0]   MODE_NORMAL = 2'h0;
	localparam logic [1:0]   MODE_SEEK   = 2'h1;
	localparam logic [1:0]   MODE_SLOW   = 2'h2;

	localparam logic [5:0]   REG_CTRL     = 6'h00;
	localparam logic [5:0]   REG_STATUS   = 6'h01;
	localparam logic [5:0]   REG_IRQ_STAT = 6'h02;
	localparam logic [5:0]   REG_IRQ_MASK = 6'h03;
	localparam logic [0:0]   CTRL_RESET   = 1'h1;
	localparam logic [3:0]   MASK_RESET   = 4'h0;

	localparam int EV_ACCEPT = 0;
	localparam int EV_READY  = 1;
	localparam int EV_ERROR  = 2;
	localparam int EV_BATCH  = 3;

	typedef enum logic [2:0] {
		S_HOME_GO,
		S_HOME_WAIT,
		S_IDLE,
		S_EXEC,
		S_MOVE_WAIT,
		S_SEEK_WAIT,
		S_SLOW_WAIT,
		S_NEXT
	} state_e;

endpackage

/* core/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pins in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

/* core/fw_cmd_port.sv */
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module fw_cmd_port
	import fw_pkg::*;
#(
	parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// host command lines and status lines
	input  wire logic [7:0]  cmd_pins,
	output logic             busy,
	output logic             error,
	// wheel sensors and motor sequencer
	input  wire logic [3:0]  sensor_pos,
	input  wire logic        motion_done,
	output logic             move_start,
	output logic             move_wheel,
	output logic [3:0]       move_target,
	output logic [2:0]       move_speed,
	output logic [1:0]       move_mode,
	// shutters
	output logic             shutter_a,
	output logic             shutter_b,
	output logic             shutter_cond_a,
	output logic             shutter_cond_b,
	// interrupt
	output logic             irq
);
	localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYC - 1);

	// synchronised pins
	logic [12:0] pins_s;
	logic [7:0]  cmd_s;
	logic [3:0]  pos_s;
	logic        done_s;
	logic        done_q;
	logic        done_rise;

	// sampling
	logic [15:0] samp_cnt;
	logic        tick;
	logic        new_cmd;
	logic        idle_go;

	// command engine
	state_e      state;
	logic [7:0]  cur;
	logic [7:0]  accepted;
	logic [2:0]  spd [2];
	logic [3:0]  pos [2];
	logic        home_wheel;
	logic        batch_on;
	logic        batch_run;
	logic        run_last;
	logic [1:0]  bidx;
	logic [7:0]  bbuf [4];
	state_e      fin_state;

	// decode of the current command
	logic        cw;
	logic [2:0]  csp;
	logic [3:0]  cfl;
	logic        is_pos;
	logic        spd_chg;
	logic        fil_chg;
	logic        is_shut;
	logic        target_ok;

	// registers and interrupts
	logic        samp_en;
	logic [3:0]  irq_stat;
	logic [3:0]  irq_mask;
	logic [3:0]  ev;
	logic        a_wr;
	logic [5:0]  a_idx;
	logic        a_take;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        wr_mask;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	pin_sync #(
		.W(13)
	) u_sync (
		.clk   (hclk),
		.rst_n (hresetn),
		.d     ({~motion_done, sensor_pos, cmd_pins}),
		.q     (pins_s)
	);

	assign cmd_s     = pins_s[7:0];
	assign pos_s     = pins_s[11:8];
	// done idles high; carried inverted so the zero reset of the sync shows no rise
	assign done_s    = ~pins_s[12];
	assign done_rise = done_s & ~done_q;

	// command lines are only compared on a sample tick and only while idle
	assign tick    = (samp_cnt == SAMPLE_LAST);
	assign new_cmd = tick & samp_en & (cmd_s != accepted);
	assign idle_go = (state == S_IDLE) & new_cmd;

	// field split: wheel * 128 + speed * 16 + filter
	assign cw        = cur[WHEEL_BIT];
	assign csp       = cur[SPEED_LSB +: 3];
	assign cfl       = cur[3:0];
	assign is_pos    = (cfl <= FILTER_LAST);
	assign spd_chg   = (csp != spd[cw]);
	assign fil_chg   = (cfl != pos[cw]);
	assign target_ok = (pos_s == move_target);
	assign is_shut   = (cur == CMD_OPEN_A) | (cur == CMD_COND_A) | (cur == CMD_CLOSE_A)
	                 | (cur == CMD_OPEN_B) | (cur == CMD_COND_B) | (cur == CMD_CLOSE_B);
	assign fin_state = batch_run ? S_NEXT : S_IDLE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_cnt <= '0;
			done_q   <= 1'b1;
		end else begin
			samp_cnt <= tick ? 16'h0000 : samp_cnt + 16'h0001;
			done_q   <= done_s;
		end
	end

	// busy follows the engine; it drops one cycle after the engine is idle again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b1;
		end else begin
			busy <= (state != S_IDLE) | idle_go;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state          <= S_HOME_GO;
			cur            <= 8'h00;
			accepted       <= 8'h00;
			spd[0]         <= 3'h0;
			spd[1]         <= 3'h0;
			pos[0]         <= HOME_POS;
			pos[1]         <= HOME_POS;
			home_wheel     <= 1'b0;
			batch_on       <= 1'b0;
			batch_run      <= 1'b0;
			run_last       <= 1'b0;
			bidx           <= 2'h0;
			bbuf[0]        <= 8'h00;
			bbuf[1]        <= 8'h00;
			bbuf[2]        <= 8'h00;
			bbuf[3]        <= 8'h00;
			error          <= 1'b0;
			move_start     <= 1'b0;
			move_wheel     <= 1'b0;
			move_target    <= HOME_POS;
			move_speed     <= 3'h0;
			move_mode      <= MODE_NORMAL;
			shutter_a      <= 1'b0;
			shutter_b      <= 1'b0;
			shutter_cond_a <= 1'b0;
			shutter_cond_b <= 1'b0;
		end else begin
			move_start <= 1'b0;
			case (state)
				// power-up homing of both wheels, busy held high throughout
				S_HOME_GO: begin
					move_start  <= 1'b1;
					move_wheel  <= home_wheel;
					move_target <= HOME_POS;
					move_mode   <= MODE_SEEK;
					state       <= S_HOME_WAIT;
				end
				S_HOME_WAIT: begin
					if (done_rise && pos_s == HOME_POS) begin
						pos[home_wheel] <= HOME_POS;
						home_wheel      <= 1'b1;
						state           <= home_wheel ? S_IDLE : S_HOME_GO;
					end else if (done_rise) begin
						state <= S_HOME_GO;
					end
				end
				S_IDLE: begin
					if (new_cmd) begin
						cur   <= cmd_s;
						state <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (batch_on) begin
						// collect only; each of the first three stored codes releases busy at once, the fourth starts the run
						bbuf[bidx] <= cur;
						accepted   <= cur;
						bidx       <= bidx + 2'h1;
						if (bidx == BATCH_LAST) begin
							batch_on  <= 1'b0;
							batch_run <= 1'b1;
							state     <= S_NEXT;
						end else begin
							state <= S_IDLE;
						end
					end else if (cur == CMD_BATCH && !batch_run) begin
						batch_on <= 1'b1;
						bidx     <= 2'h0;
						accepted <= cur;
						state    <= S_IDLE;
					end else if (is_shut) begin
						// shutter changes finish in a few cycles
						if (cur == CMD_OPEN_A || cur == CMD_CLOSE_A || cur == CMD_COND_A) begin
							shutter_a      <= (cur != CMD_CLOSE_A);
							shutter_cond_a <= (cur == CMD_COND_A);
						end else begin
							shutter_b      <= (cur != CMD_CLOSE_B);
							shutter_cond_b <= (cur == CMD_COND_B);
						end
						if (!batch_run) begin
							accepted <= cur;
						end
						state <= fin_state;
					end else if (!is_pos) begin
						// on-line and unknown codes are taken without action
						if (!batch_run) begin
							accepted <= cur;
						end
						state <= fin_state;
					end else if (spd_chg && !batch_run) begin
						// old filter kept as accepted, so the next sample acts on it
						spd[cw]  <= csp;
						accepted <= {cur[7:4], pos[cw]};
						state    <= S_IDLE;
					end else begin
						spd[cw] <= csp;
						if (!batch_run) begin
							accepted <= cur;
						end
						if (fil_chg) begin
							move_start  <= 1'b1;
							move_wheel  <= cw;
							move_target <= cfl;
							move_speed  <= csp;
							move_mode   <= MODE_NORMAL;
							state       <= S_MOVE_WAIT;
						end else begin
							state <= fin_state;
						end
					end
				end
				S_MOVE_WAIT: begin
					if (done_rise && target_ok) begin
						pos[cw] <= cfl;
						state   <= fin_state;
					end else if (done_rise) begin
						error       <= 1'b1;
						move_start  <= 1'b1;
						move_target <= HOME_POS;
						move_mode   <= MODE_SEEK;
						state       <= S_SEEK_WAIT;
					end
				end
				S_SEEK_WAIT: begin
					if (done_rise && pos_s == HOME_POS) begin
						error       <= 1'b0;
						move_start  <= 1'b1;
						move_target <= cfl;
						move_mode   <= MODE_SLOW;
						state       <= S_SLOW_WAIT;
					end else if (done_rise) begin
						move_start <= 1'b1;
					end
				end
				S_SLOW_WAIT: begin
					// busy stays up until the slow move lands
					if (done_rise) begin
						pos[cw] <= cfl;
						state   <= fin_state;
					end
				end
				S_NEXT: begin
					// stored batch codes run back to back without resampling
					if (run_last) begin
						batch_run <= 1'b0;
						run_last  <= 1'b0;
						state     <= S_IDLE;
					end else begin
						cur      <= bbuf[bidx];
						bidx     <= bidx + 2'h1;
						run_last <= (bidx == BATCH_LAST);
						state    <= S_EXEC;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// events: accepted, ready again, error found, batch finished
	assign ev[EV_ACCEPT] = idle_go;
	assign ev[EV_READY]  = busy & (state == S_IDLE) & ~idle_go;
	assign ev[EV_ERROR]  = (state == S_MOVE_WAIT) & done_rise & ~target_ok;
	assign ev[EV_BATCH]  = (state == S_NEXT) & run_last;

	// ahb-lite: zero wait states, address phase captured for the data phase
	assign a_take  = hsel & htrans[1] & hready;
	assign wr_ctrl = a_wr & (a_idx == REG_CTRL);
	assign wr_stat = a_wr & (a_idx == REG_IRQ_STAT);
	assign wr_mask = a_wr & (a_idx == REG_IRQ_MASK);

	assign status_word = {8'h00, pos[1], pos[0], accepted,
	                      4'h0, batch_run, batch_on, error, busy};

	// unmapped words read as zero
	assign rd_mux = (haddr[7:2] == REG_CTRL)     ? {31'h0, samp_en} :
	                (haddr[7:2] == REG_STATUS)   ? status_word :
	                (haddr[7:2] == REG_IRQ_STAT) ? {28'h0, irq_stat} :
	                (haddr[7:2] == REG_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr      <= 1'b0;
			a_idx     <= 6'h00;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			a_wr      <= a_take & hwrite & (hsize == 3'h2);
			a_idx     <= haddr[7:2];
			hrdata    <= (a_take && !hwrite) ? rd_mux : 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// new events win over a write-one-to-clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_en  <= CTRL_RESET;
			irq_mask <= MASK_RESET;
			irq_stat <= 4'h0;
			irq      <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				samp_en <= hwdata[0];
			end
			if (wr_mask) begin
				irq_mask <= hwdata[3:0];
			end
			irq_stat <= (irq_stat & ~(wr_stat ? hwdata[3:0] : 4'h0)) | ev;
			irq      <= |(irq_stat & irq_mask);
		end
	end

endmodule
`default_nettype wire

/* tb/wheel_model.sv */
`timescale 1ns/100ps
`default_nettype none
module wheel_model
	import fw_pkg::*;
(
	// clock and scenario control
	input  wire logic       hclk,
	input  wire logic       misplace,
	input  wire logic [5:0] dly,
	// motor sequencer side
	input  wire logic       move_start,
	input  wire logic [3:0] move_target,
	input  wire logic [1:0] move_mode,
	output logic      [3:0] sensor_pos,
	output logic            motion_done
);
	int         left = 0;
	logic [3:0] dest = 4'h0;
	initial begin
		sensor_pos = 4'h0;
		motion_done = 1'b1;
	end
	always @(posedge hclk) begin
		if (move_start) begin
			// a seek always ends on position 0
			dest <= (move_mode == MODE_SEEK) ? HOME_POS :
				(misplace && move_mode == MODE_NORMAL) ? move_target + 4'h1 : move_target;
			left <= dly + 2;
			motion_done <= 1'b0;
		end else if (left > 0) begin
			left <= left - 1;
			// sensors read junk while turning, so a stale value cannot pass
			sensor_pos <= (left > 2) ? sensor_pos + 4'h5 : dest;
			motion_done <= (left == 1);
		end
	end
endmodule
`default_nettype wire

/* tb/fw_cmd_port_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module fw_cmd_port_sva
	import fw_pkg::*;
(
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// status and move request
	input wire logic       busy,
	input wire logic       error,
	input wire logic       move_start,
	input wire logic [3:0] move_target,
	input wire logic [1:0] move_mode
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// busy cycles with no move yet; homing counts as moved
	int   quick;
	logic moved;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quick <= 0;
			moved <= 1'b1;
		end else begin
			moved <= busy && (moved || move_start);
			quick <= (busy && !moved && !move_start) ? quick + 1 : 0;
		end
	end
	sequence seek_go;
		move_start && move_mode == MODE_SEEK && move_target == HOME_POS;
	endsequence
	sequence slow_go;
		move_start && move_mode == MODE_SLOW;
	endsequence
	chk_err_busy: assert property (error |-> busy)
		else $error("error without busy");
	chk_err_entry: assert property ($rose(error) |-> $past(busy))
		else $error("error outside a move");
	chk_err_seek: assert property ($rose(error) |-> ##[0:2] seek_go)
		else $error("no seek to zero after error");
	chk_err_slow: assert property ($fell(error) |-> ##[0:2] slow_go)
		else $error("no slow move after zero");
	chk_busy_end: assert property ($fell(busy) |-> !error && !$past(error))
		else $error("busy fell during recovery");
	chk_start_busy: assert property (move_start |-> busy)
		else $error("move without busy");
	chk_move_hold: assert property (move_start |=> busy [*4])
		else $error("busy dropped mid move");
	chk_quick_cmd: assert property (quick < 100000)
		else $error("short command busy too long");
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fw_pkg::*;
	localparam int SC = 20;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, busy, error, motion_done, move_start, irq, sh_a, sh_b;
	logic        hresp, cond_a, move_wheel;
	logic [2:0]  move_speed;
	logic [7:0]  cmd_pins = 8'h00;
	logic [3:0]  sensor_pos, move_target;
	logic [1:0]  move_mode;
	logic        misplace = 1'b0;
	logic [5:0]  dly = 6'h3;
	logic [31:0] exp_q[$], msk_q[$];
	logic        rd_phase = 1'b0;
	int          err_count = 0, num_checks = 0, starts = 0, saw_err = 0;

	initial forever #5 hclk = ~hclk;

	fw_cmd_port #(.SAMPLE_CYC(SC)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cmd_pins(cmd_pins), .busy(busy), .error(error), .sensor_pos(sensor_pos),
		.motion_done(motion_done), .move_start(move_start), .move_wheel(move_wheel),
		.move_target(move_target), .move_speed(move_speed), .move_mode(move_mode),
		.shutter_a(sh_a), .shutter_b(sh_b), .shutter_cond_a(cond_a), .shutter_cond_b(),
		.irq(irq));
	wheel_model wheel_u (.hclk(hclk), .misplace(misplace), .dly(dly), .move_start(move_start),
		.move_target(move_target), .move_mode(move_mode), .sensor_pos(sensor_pos),
		.motion_done(motion_done));

	always @(posedge hclk) begin
		if (move_start)
			starts++;
		if (error === 1'b1)
			saw_err = 1;
		if (rd_phase && hreadyout === 1'b1) begin
			num_checks++;
			if ((hrdata & msk_q[0]) !== exp_q[0]) begin
				err_count++;
				$display("unexpected read: expected %h seen %h", exp_q[0], hrdata & msk_q[0]);
			end
			if (hresp !== 1'b0) begin
				err_count++;
				$display("unexpected hresp: expected 0 seen %b", hresp);
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string what, input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			err_count++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_phase <= !wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_phase <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		ahb(1'b0, a, 32'h0);
	endtask
	task automatic wait_low();
		int t;
		t = 0;
		while (busy !== 1'b0 && t < 3000) begin
			@(posedge hclk);
			t++;
		end
		check("busy low", t < 3000, 1);
	endtask
	// one command, then each busy pulse it causes; a low is trusted only
	// after the full sample and busy delay has run out
	task automatic send(input logic [7:0] c, input int mv, input int pulses);
		int n0, t;
		n0 = starts;
		@(posedge hclk);
		dly <= 6'($urandom_range(40, 2));
		cmd_pins <= c;
		repeat (pulses) begin
			t = 0;
			while (busy !== 1'b1 && t < 200) begin
				@(posedge hclk);
				t++;
			end
			check("busy rise", t <= 2 * SC + 3, 1);
			wait_low();
		end
		check("moves", starts - n0, mv);
	endtask

	initial begin
		int f, n;
		logic [7:0] c;
		void'($urandom(88));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		wait_low();
		repeat (3 * SC) @(posedge hclk);
		wait_low();
		rd(32'h0, 32'h1, 32'h1);
		rd(32'hC, 32'h0, 32'hF);
		rd(32'h10, 32'h0, 32'hFFFFFFFF);
		ahb(1'b1, 32'h8, 32'hF);
		ahb(1'b1, 32'hC, 32'h1);
		send(8'h09, 1, 1);
		repeat (2) @(posedge hclk);
		check("irq set", irq === 1'b1, 1);
		ahb(1'b1, 32'h8, 32'h1);
		repeat (2) @(posedge hclk);
		check("irq clear", irq === 1'b0, 1);
		ahb(1'b1, 32'hC, 32'h0);
		f = 9;
		for (n = 0; n < 4; n++) begin
			f = (f + 1 + $urandom % 9) % 10;
			c = {4'h0, 4'(f)};
			send(c, 1, 1);
			rd(32'h4, {12'h0, 4'(f), c, 8'h0}, 32'h000FFF00);
		end
		send({4'h3, 4'(f)}, 0, 1);
		f = (f + 3) % 10;
		send({4'h5, 4'(f)}, 1, 2);
		check("move speed", move_speed, 5);
		f = (f + 4) % 10;
		misplace <= 1'b1;
		send({4'h5, 4'(f)}, 3, 1);
		misplace <= 1'b0;
		check("error seen", saw_err, 1);
		rd(32'h4, {12'h0, 4'(f), 16'h0}, 32'h000F0003);
		// lines wiggle mid move and come back; nothing new may be taken
		n = starts;
		f = (f + 1) % 10;
		c = {4'h5, 4'(f)};
		@(posedge hclk);
		cmd_pins <= c;
		wait (busy === 1'b1);
		dly <= 6'h28;
		cmd_pins <= ~c;
		repeat (SC) @(posedge hclk);
		cmd_pins <= c;
		wait_low();
		repeat (3 * SC) @(posedge hclk);
		check("ignored", starts - n, 1);
		check("idle", busy === 1'b0, 1);
		// sampling switched off: a changed line must wait for it to come back
		ahb(1'b1, 32'h0, 32'h0);
		cmd_pins <= CMD_OPEN_A;
		repeat (3 * SC) @(posedge hclk);
		check("sampling off", busy === 1'b0, 1);
		ahb(1'b1, 32'h0, 32'h1);
		send(CMD_OPEN_A, 0, 1);
		check("shutter a", sh_a === 1'b1, 1);
		send(CMD_OPEN_B, 0, 1);
		check("shutter b", sh_b === 1'b1, 1);
		send(CMD_COND_A, 0, 1);
		check("shutter cond a", {sh_a, cond_a} === 2'b11, 1);
		send(CMD_CLOSE_A, 0, 1);
		send(CMD_CLOSE_B, 0, 1);
		check("shutters shut", {sh_a, sh_b, cond_a} === 3'b000, 1);
		send(CMD_BATCH, 0, 1);
		send(CMD_OPEN_A, 0, 1);
		send(CMD_OPEN_B, 0, 1);
		send({4'h5, 4'((f + 2) % 10)}, 0, 1);
		send(8'h85, 2, 1);
		check("move wheel", move_wheel === 1'b1, 1);
		rd(32'h4, 32'h00500000, 32'h00F00000);
		check("batch shutter", sh_a === 1'b1, 1);
		wrap_up();
	end

	initial begin
		repeat (60000) @(posedge hclk);
		err_count++;
		wrap_up();
	end
endmodule

bind fw_cmd_port fw_cmd_port_sva chk_u (.hclk(hclk), .hresetn(hresetn), .busy(busy),
	.error(error), .move_start(move_start), .move_target(move_target), .move_mode(move_mode));
`default_nettype wire
